// File: design/ufc_char_ram.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_char_ram #(
    parameter int W = 8,
    parameter int AW = 6
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem [0:(1<<AW)-1];
    logic [W-1:0] rdata_nxt;

    // Forwarding keeps the head valid one cycle after a write to it
    always_comb
    begin
        rdata_nxt = (we_i && (waddr_i == raddr_i)) ? wdata_i : mem[raddr_i];
    end

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= rdata_nxt;
    end
endmodule : ufc_char_ram
`default_nettype wire

// File: design/ufc_flow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.svh"
module ufc_flow_ctrl #(
    parameter int DEPTH = `UFC_FIFO_DEPTH,
    parameter int AW = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ufc_pkg::ufc_req_t req_i,
    output logic [7:0] reg_rdata_o,
    input wire ufc_pkg::ufc_char_t rx_char_i,
    input wire logic tx_busy_i,
    output ufc_pkg::ufc_char_t tx_char_o,
    input wire logic cts_n_i,
    output logic rts_n_o,
    output logic sleep_o
);
    import ufc_pkg::*;

    logic [7:0] lcr_r, lcr_nxt, efr_r, efr_nxt, sfr_r, sfr_nxt, ier_r, ier_nxt;
    logic [7:0] mcr_r, mcr_nxt, tcr_r, tcr_nxt, tlp_r, tlp_nxt, fcr_r, fcr_nxt;
    logic [7:0] resume_char_first_r, resume_char_first_nxt, resume_char_second_r, resume_char_second_nxt, pause_char_first_r, pause_char_first_nxt, pause_char_second_r, pause_char_second_nxt;
    logic paused_r, paused_nxt, xoff_sent_r, xoff_sent_nxt;
    logic xoff_flag_r, xoff_flag_nxt, spec_flag_r, spec_flag_nxt, ovr_r, ovr_nxt;
    logic rts_act_r, rts_act_nxt, rts_n_nxt, sleep_nxt;
    logic [7:0] rdata_nxt, second_r, second_nxt;
    ufc_char_t tx_char_nxt;
    ufc_txs_t txs_r, txs_nxt;
    logic cts_s1_r, cts_s2_r;
    logic [AW-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt, rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
    logic [AW:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt, cap, halt_lvl, res_lvl;
    logic [7:0] tx_head, rx_head, interrupt_ident_reg;
    logic tx_push, tx_pop, rx_push, rx_pop, flush_tx, flush_rx;
    logic bf, efr_vis, enh, fifo_en, cts_ok, can_go, spec, xon_hit, xoff_hit;
    logic need_xoff, need_xon;
    logic [1:0] sw_tx, sw_rx;

    function automatic logic [AW:0] trig(input logic [1:0] sel, input logic en,
                                          input logic is_rx);
        logic [6:0] t;
        t = 7'd1;
        if (en)
        begin
            case (sel)
                2'd0: t = is_rx ? `UFC_RXT0 : `UFC_TXT0;
                2'd1: t = is_rx ? `UFC_RXT1 : `UFC_TXT1;
                2'd2: t = is_rx ? `UFC_RXT2 : `UFC_TXT2;
                default: t = is_rx ? `UFC_RXT3 : `UFC_TXT3;
            endcase
        end
        return (AW+1)'(t);
    endfunction : trig

    // Nibble of the trigger control register in units of four characters
    function automatic logic [AW:0] lvl(input logic [3:0] nib);
        return (AW+1)'({nib, 2'b00});
    endfunction : lvl

    assign bf = (lcr_r == `UFC_LCR_GATE);
    assign efr_vis = bf && !sfr_r[`UFC_SFR_HIDE_BIT];
    assign enh = efr_r[`UFC_EFR_ENH_BIT];
    assign fifo_en = fcr_r[0];
    assign cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
    assign sw_tx = efr_r[`UFC_EFR_SWTX_HI:`UFC_EFR_SWTX_LO];
    assign sw_rx = efr_r[`UFC_EFR_SWRX_HI:`UFC_EFR_SWRX_LO];
    // Zero in the halt nibble would hold the line off for ever, so it means full
    assign halt_lvl = !fifo_en ? (AW+1)'(1) : (tcr_r[3:0] == 4'h0) ? cap : lvl(tcr_r[3:0]);
    assign res_lvl = fifo_en ? lvl(tcr_r[7:4]) : '0;
    // CTS is a pin, so only the second stage is read
    assign cts_ok = !efr_r[`UFC_EFR_CTS_BIT] || !cts_s2_r;
    assign can_go = !tx_busy_i && !tx_char_o.valid && cts_ok;
    assign spec = efr_r[`UFC_EFR_SPEC_BIT] && (rx_char_i.data == pause_char_second_r);

    ufc_char_ram #(.W(8), .AW(AW)) u_tx_ram (
        .clk_i(clk_i),
        .we_i(tx_push),
        .waddr_i(tx_wp_r),
        .wdata_i(req_i.wdata),
        .raddr_i(tx_rp_r),
        .rdata_o(tx_head)
    );

    ufc_char_ram #(.W(8), .AW(AW)) u_rx_ram (
        .clk_i(clk_i),
        .we_i(rx_push),
        .waddr_i(rx_wp_r),
        .wdata_i(rx_char_i.data),
        .raddr_i(rx_rp_r),
        .rdata_o(rx_head)
    );

    always_comb
    begin
        // High select bit compares the first pair, low bit the second; both means either
        xon_hit = (sw_rx[1] && (rx_char_i.data == resume_char_first_r))
                  || (sw_rx[0] && (rx_char_i.data == resume_char_second_r));
        xoff_hit = (sw_rx[1] && (rx_char_i.data == pause_char_first_r))
                   || (sw_rx[0] && (rx_char_i.data == pause_char_second_r));
        interrupt_ident_reg = {{2{fifo_en}}, `UFC_IIR_NONE};
        if (ier_r[0] && (rx_cnt_r >= trig(fcr_r[7:6], fifo_en, 1'b1)))
        begin
            interrupt_ident_reg[5:0] = `UFC_IIR_RX;
        end
        else if (ier_r[1] && ((cap - tx_cnt_r) >= trig(fcr_r[5:4], fifo_en, 1'b0)))
        begin
            interrupt_ident_reg[5:0] = `UFC_IIR_TX;
        end
        else if (ier_r[5] && (xoff_flag_r || spec_flag_r))
        begin
            interrupt_ident_reg[5:0] = `UFC_IIR_XOFF;
        end
        need_xoff = (sw_tx != 2'b00) && !xoff_sent_r && (rx_cnt_r >= halt_lvl);
        need_xon = xoff_sent_r && ((rx_cnt_r <= res_lvl) || (sw_tx == 2'b00));
    end

    always_comb
    begin
        {lcr_nxt, efr_nxt, sfr_nxt, ier_nxt} = {lcr_r, efr_r, sfr_r, ier_r};
        {mcr_nxt, tcr_nxt, tlp_nxt, fcr_nxt} = {mcr_r, tcr_r, tlp_r, fcr_r};
        {resume_char_first_nxt, resume_char_second_nxt, pause_char_first_nxt, pause_char_second_nxt} = {resume_char_first_r, resume_char_second_r, pause_char_first_r, pause_char_second_r};
        {paused_nxt, xoff_flag_nxt, spec_flag_nxt, ovr_nxt} =
            {paused_r, xoff_flag_r, spec_flag_r, ovr_r};
        rdata_nxt = reg_rdata_o;
        {flush_tx, flush_rx, tx_push, rx_pop} = 4'h0;
        if (req_i.wr)
        begin
            case (req_i.addr)
                `UFC_OFF_DATA: tx_push = !bf && (tx_cnt_r < cap);
                `UFC_OFF_IER:
                begin
                    if (bf)
                        sfr_nxt = req_i.wdata;
                    else
                        ier_nxt = {enh ? req_i.wdata[7:4] : ier_r[7:4], req_i.wdata[3:0]};
                end
                `UFC_OFF_SHARED:
                begin
                    if (efr_vis)
                        efr_nxt = req_i.wdata;
                    else if (!bf && req_i.wdata[0])
                    begin
                        fcr_nxt = {req_i.wdata[7:6], enh ? req_i.wdata[5:4] : fcr_r[5:4],
                                   4'h1};
                        flush_rx = req_i.wdata[1] || !fifo_en;
                        flush_tx = req_i.wdata[2] || !fifo_en;
                    end
                    else if (!bf)
                    begin
                        fcr_nxt = {fcr_r[7:1], 1'b0};
                        flush_rx = fifo_en;
                        flush_tx = fifo_en;
                    end
                end
                `UFC_OFF_LCR: lcr_nxt = req_i.wdata;
                `UFC_OFF_MCR:
                begin
                    if (bf)
                        resume_char_first_nxt = req_i.wdata;
                    else
                        mcr_nxt = {enh ? req_i.wdata[7:5] : mcr_r[7:5], req_i.wdata[4:0]};
                end
                `UFC_OFF_LSR: resume_char_second_nxt = bf ? req_i.wdata : resume_char_second_r;
                `UFC_OFF_TCR:
                begin
                    if (bf)
                        pause_char_first_nxt = req_i.wdata;
                    else if (enh)
                        tcr_nxt = req_i.wdata;
                end
                default:
                begin
                    if (bf)
                        pause_char_second_nxt = req_i.wdata;
                    else if (enh)
                        tlp_nxt = req_i.wdata;
                end
            endcase
        end
        if (req_i.rd)
        begin
            case (req_i.addr)
                `UFC_OFF_DATA:
                begin
                    rdata_nxt = bf ? `UFC_RST_ZERO : rx_head;
                    rx_pop = !bf && (rx_cnt_r != '0);
                end
                `UFC_OFF_IER: rdata_nxt = bf ? sfr_r : ier_r;
                `UFC_OFF_SHARED:
                begin
                    rdata_nxt = efr_vis ? efr_r : interrupt_ident_reg;
                    if (!efr_vis && interrupt_ident_reg[5:0] == `UFC_IIR_XOFF)
                    begin
                        xoff_flag_nxt = 1'b0;
                        spec_flag_nxt = 1'b0;
                    end
                end
                `UFC_OFF_LCR: rdata_nxt = lcr_r;
                `UFC_OFF_MCR: rdata_nxt = bf ? resume_char_first_r : mcr_r;
                `UFC_OFF_LSR:
                begin
                    rdata_nxt = bf ? resume_char_second_r : {1'b0, tx_cnt_r == '0 && !tx_busy_i,
                                               tx_cnt_r < cap, 3'b000, ovr_r, rx_cnt_r != '0};
                    ovr_nxt = bf ? ovr_r : 1'b0;
                end
                `UFC_OFF_TCR: rdata_nxt = bf ? pause_char_first_r : tcr_r;
                default: rdata_nxt = bf ? pause_char_second_r : tlp_r;
            endcase
        end
        // Receive side: flags set after the read clear, so a new event wins
        rx_push = 1'b0;
        if (rx_char_i.valid)
        begin
            if (xoff_hit)
            begin
                paused_nxt = 1'b1;
                xoff_flag_nxt = 1'b1;
                spec_flag_nxt = spec_flag_nxt || spec;
            end
            else if (xon_hit)
            begin
                paused_nxt = 1'b0;
            end
            else
            begin
                rx_push = (rx_cnt_r < cap) && !flush_rx;
                ovr_nxt = ovr_nxt || (rx_cnt_r >= cap);
                spec_flag_nxt = spec_flag_nxt || spec;
            end
        end
        if (sw_rx == 2'b00)
        begin
            paused_nxt = 1'b0;
        end
    end

    // Transmit launch: flow characters first, then data
    always_comb
    begin
        txs_nxt = txs_r;
        second_nxt = second_r;
        xoff_sent_nxt = xoff_sent_r;
        tx_char_nxt = '0;
        tx_pop = 1'b0;
        case (txs_r)
            UFC_TX_IDLE:
            begin
                if (can_go && (need_xoff || need_xon))
                begin
                    // One pause per crossing of the halt level, cleared by the resume
                    xoff_sent_nxt = need_xoff;
                    case (sw_tx)
                        2'b10: tx_char_nxt.data = need_xoff ? pause_char_first_r : resume_char_first_r;
                        2'b01: tx_char_nxt.data = need_xoff ? pause_char_second_r : resume_char_second_r;
                        2'b11:
                        begin
                            tx_char_nxt.data = need_xoff ? pause_char_first_r : resume_char_first_r;
                            second_nxt = need_xoff ? pause_char_second_r : resume_char_second_r;
                            txs_nxt = UFC_TX_SECOND;
                        end
                        default: tx_char_nxt.data = resume_char_first_r;
                    endcase
                    tx_char_nxt.valid = (sw_tx != 2'b00) || need_xoff;
                end
                else if (can_go && (tx_cnt_r != '0) && !paused_r && !flush_tx)
                begin
                    tx_char_nxt = '{valid: 1'b1, data: tx_head};
                    tx_pop = 1'b1;
                end
            end
            UFC_TX_SECOND:
            begin
                if (can_go)
                begin
                    tx_char_nxt = '{valid: 1'b1, data: second_r};
                    txs_nxt = UFC_TX_IDLE;
                end
            end
            default: txs_nxt = UFC_TX_IDLE;
        endcase
    end

    always_comb
    begin
        tx_wp_nxt = flush_tx ? '0 : tx_wp_r + AW'(tx_push);
        tx_rp_nxt = flush_tx ? '0 : tx_rp_r + AW'(tx_pop);
        tx_cnt_nxt = flush_tx ? '0 : tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        rx_wp_nxt = flush_rx ? '0 : rx_wp_r + AW'(rx_push);
        rx_rp_nxt = flush_rx ? '0 : rx_rp_r + AW'(rx_pop);
        rx_cnt_nxt = flush_rx ? '0 : rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        rts_act_nxt = rts_act_r;
        if (rx_cnt_r >= halt_lvl)
            rts_act_nxt = 1'b0;
        else if (rx_cnt_r <= res_lvl)
            rts_act_nxt = 1'b1;
        rts_n_nxt = efr_r[`UFC_EFR_RTS_BIT] ? !rts_act_nxt : !mcr_r[1];
        sleep_nxt = enh && ier_r[4] && (tx_cnt_r == '0) && (rx_cnt_r == '0)
                    && !tx_busy_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lcr_r <= `UFC_RST_LCR;
            efr_r <= `UFC_RST_EFR;
            {sfr_r, ier_r, mcr_r, tcr_r, tlp_r, fcr_r} <= '0;
            {resume_char_first_r, resume_char_second_r, pause_char_first_r, pause_char_second_r, second_r} <= '0;
            {paused_r, xoff_sent_r, xoff_flag_r, spec_flag_r, ovr_r} <= '0;
            {rts_act_r, rts_n_o} <= 2'h3;
            sleep_o <= 1'b0;
            reg_rdata_o <= `UFC_RST_ZERO;
            tx_char_o <= '0;
            txs_r <= UFC_TX_IDLE;
            {cts_s1_r, cts_s2_r} <= 2'b11;
            {tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r} <= '0;
            {tx_cnt_r, rx_cnt_r} <= '0;
        end
        else
        begin
            lcr_r <= lcr_nxt;
            efr_r <= efr_nxt;
            {sfr_r, ier_r, mcr_r, tcr_r, tlp_r, fcr_r} <=
                {sfr_nxt, ier_nxt, mcr_nxt, tcr_nxt, tlp_nxt, fcr_nxt};
            {resume_char_first_r, resume_char_second_r, pause_char_first_r, pause_char_second_r, second_r} <=
                {resume_char_first_nxt, resume_char_second_nxt, pause_char_first_nxt, pause_char_second_nxt, second_nxt};
            {paused_r, xoff_sent_r, xoff_flag_r, spec_flag_r, ovr_r} <=
                {paused_nxt, xoff_sent_nxt, xoff_flag_nxt, spec_flag_nxt, ovr_nxt};
            {rts_act_r, rts_n_o, sleep_o} <= {rts_act_nxt, rts_n_nxt, sleep_nxt};
            reg_rdata_o <= rdata_nxt;
            tx_char_o <= tx_char_nxt;
            txs_r <= txs_nxt;
            {cts_s2_r, cts_s1_r} <= {cts_s1_r, cts_n_i};
            {tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r} <= {tx_wp_nxt, tx_rp_nxt, rx_wp_nxt, rx_rp_nxt};
            {tx_cnt_r, rx_cnt_r} <= {tx_cnt_nxt, rx_cnt_nxt};
        end
    end
endmodule : ufc_flow_ctrl
`default_nettype wire

// File: design/ufc_map.svh
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH
`define UFC_OFF_DATA 3'h0
`define UFC_OFF_IER 3'h1
`define UFC_OFF_SFR 3'h1
`define UFC_OFF_SHARED 3'h2
`define UFC_OFF_LCR 3'h3
`define UFC_OFF_MCR 3'h4
`define UFC_OFF_RESUME_CHAR_FIRST 3'h4
`define UFC_OFF_LSR 3'h5
`define UFC_OFF_RESUME_CHAR_SECOND 3'h5
`define UFC_OFF_TCR 3'h6
`define UFC_OFF_PAUSE_CHAR_FIRST 3'h6
`define UFC_OFF_TLP 3'h7
`define UFC_OFF_PAUSE_CHAR_SECOND 3'h7
`define UFC_LCR_GATE 8'hBF
`define UFC_SFR_HIDE_BIT 2
`define UFC_EFR_CTS_BIT 7
`define UFC_EFR_RTS_BIT 6
`define UFC_EFR_SPEC_BIT 5
`define UFC_EFR_ENH_BIT 4
`define UFC_EFR_SWTX_HI 3
`define UFC_EFR_SWTX_LO 2
`define UFC_EFR_SWRX_HI 1
`define UFC_EFR_SWRX_LO 0
`define UFC_RST_EFR 8'h00
`define UFC_RST_LCR 8'h1D
`define UFC_RST_ZERO 8'h00
`define UFC_IIR_NONE 6'h01
`define UFC_IIR_RX 6'h04
`define UFC_IIR_TX 6'h02
`define UFC_IIR_XOFF 6'h10
`define UFC_FIFO_DEPTH 64
`define UFC_RXT0 7'd8
`define UFC_RXT1 7'd16
`define UFC_RXT2 7'd56
`define UFC_RXT3 7'd60
`define UFC_TXT0 7'd8
`define UFC_TXT1 7'd16
`define UFC_TXT2 7'd32
`define UFC_TXT3 7'd56
`endif

// File: design/ufc_pkg.sv
package ufc_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ufc_req_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ufc_char_t;
    typedef enum logic {UFC_TX_IDLE, UFC_TX_SECOND} ufc_txs_t;
endpackage : ufc_pkg

// File: tb/tb_ufc_flow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ufc_flow_ctrl;
    import ufc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    ufc_req_t req_i = '0;
    logic [7:0] reg_rdata_o;
    ufc_char_t rx_char_i;
    logic tx_busy_i;
    ufc_char_t tx_char_o;
    logic cts_n_i = 1'b0;
    logic rts_n_o;
    logic sleep_o;
    int n_fail = 0;
    int checks_done = 0;
    logic [7:0] rd_v;
    always #2.5 clk_i = ~clk_i;
    ufc_flow_ctrl i_ufc_flow_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
        .reg_rdata_o(reg_rdata_o), .rx_char_i(rx_char_i), .tx_busy_i(tx_busy_i),
        .tx_char_o(tx_char_o), .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .sleep_o(sleep_o));
    // Partner pause and resume match the first pair programmed below
    ufc_remote_model #(.PAUSE_CHAR(8'h91), .RESUME_CHAR(8'h11))
        i_ufc_remote_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .tx_char_i(tx_char_o), .rts_n_i(rts_n_o), .rx_char_o(rx_char_i),
        .tx_busy_o(tx_busy_i));
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk_i);
        req_i = '0;
    endtask : wr
    // Extra cycle keeps receive pops three cycles apart
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk_i);
        req_i = '0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
        rd(a, rd_v);
        chk(rd_v & m, exp);
    endtask : rchk
    task automatic set_efr(input logic [7:0] d);
        wr(3'h3, 8'hBF);
        wr(3'h2, d);
        wr(3'h3, 8'h03);
    endtask : set_efr
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    // Whole sequence needs about 1300 cycles; the 12000-cycle limit is ample margin
    initial
    begin
        #60000;
        n_fail++;
        complete_run();
    end
    initial
    begin
        idle(2);
        rst_n_i = 1'b1;
        rchk(3'h3, 8'hFF, 8'h1D);
        wr(3'h3, 8'hBF);
        rchk(3'h2, 8'hFF, 8'h00);
        wr(3'h1, 8'h04);
        rchk(3'h2, 8'hFF, 8'h01);
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        wr(3'h2, 8'h31);
        wr(3'h1, 8'h02);
        i_ufc_remote_model.stall = 1'b1;
        for (int i = 0; i < 17; i++) wr(3'h0, i[7:0]);
        rchk(3'h2, 8'hFF, 8'hC2);
        set_efr(8'h10);
        wr(3'h2, 8'h31);
        rchk(3'h2, 8'hFF, 8'hC1);
        for (int i = 17; i < 66; i++) wr(3'h0, i[7:0]);
        rchk(3'h5, 8'h20, 8'h00);
        i_ufc_remote_model.stall = 1'b0;
        idle(700);
        chk(8'(i_ufc_remote_model.got_q.size()), 8'h41);
        chk(i_ufc_remote_model.got_q[64], 8'h40);
        i_ufc_remote_model.got_q.delete();
        i_ufc_remote_model.stall = 1'b1;
        wr(3'h2, 8'h00);
        for (int i = 0; i < 3; i++) wr(3'h0, 8'hA0 + i[7:0]);
        rchk(3'h2, 8'hC0, 8'h00);
        i_ufc_remote_model.stall = 1'b0;
        idle(30);
        chk(8'(i_ufc_remote_model.got_q.size()), 8'h02);
        i_ufc_remote_model.send(8'h55);
        i_ufc_remote_model.send(8'h56);
        rchk(3'h5, 8'h03, 8'h03);
        rd(3'h0, rd_v);
        wr(3'h2, 8'h01);
        set_efr(8'h50);
        wr(3'h6, 8'h11);
        i_ufc_remote_model.obey_rts = 1'b1;
        idle(3);
        chk({7'h00, rts_n_o}, 8'h00);
        repeat (4) i_ufc_remote_model.send(8'h30);
        idle(3);
        chk({7'h00, rts_n_o}, 8'h01);
        rd(3'h0, rd_v);
        idle(3);
        chk({7'h00, rts_n_o}, 8'h00);
        set_efr(8'h00);
        i_ufc_remote_model.obey_rts = 1'b0;
        idle(3);
        chk({7'h00, rts_n_o}, 8'h01);
        repeat (3) rd(3'h0, rd_v);
        i_ufc_remote_model.got_q.delete();
        set_efr(8'h80);
        cts_n_i = 1'b1;
        wr(3'h0, 8'h61);
        idle(20);
        chk(8'(i_ufc_remote_model.got_q.size()), 8'h00);
        cts_n_i = 1'b0;
        idle(20);
        chk(8'(i_ufc_remote_model.got_q.size()), 8'h01);
        set_efr(8'h00);
        cts_n_i = 1'b1;
        wr(3'h0, 8'h62);
        idle(20);
        chk(8'(i_ufc_remote_model.got_q.size()), 8'h02);
        cts_n_i = 1'b0;
        wr(3'h3, 8'hBF);
        wr(3'h4, 8'h11);
        wr(3'h5, 8'h13);
        wr(3'h6, 8'h91);
        wr(3'h7, 8'h93);
        wr(3'h2, 8'h30);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h20);
        i_ufc_remote_model.send(8'h93);
        rchk(3'h2, 8'hFF, 8'hD0);
        rchk(3'h5, 8'h01, 8'h01);
        rchk(3'h0, 8'hFF, 8'h93);
        set_efr(8'h31);
        i_ufc_remote_model.send(8'h93);
        rchk(3'h2, 8'hFF, 8'hD0);
        rchk(3'h5, 8'h01, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            set_efr({4'h1, c[1:0], c[1:0]});
            i_ufc_remote_model.send(8'h91);
            rchk(3'h5, 8'h01, {7'h00, !c[1]});
            rd(3'h0, rd_v);
            i_ufc_remote_model.send(8'h93);
            rchk(3'h5, 8'h01, {7'h00, !c[0]});
            rd(3'h0, rd_v);
        end
        wr(3'h1, 8'h30);
        idle(2);
        chk({7'h00, sleep_o}, 8'h01);
        set_efr(8'h18);
        wr(3'h6, 8'h01);
        i_ufc_remote_model.got_q.delete();
        // Halt at four held characters, resume only once drained
        repeat (4) i_ufc_remote_model.send(8'h41);
        idle(20);
        chk(8'(i_ufc_remote_model.got_q.size()), 8'h01);
        chk(i_ufc_remote_model.got_q[0], 8'h91);
        repeat (4) rd(3'h0, rd_v);
        idle(20);
        chk(8'(i_ufc_remote_model.got_q.size()), 8'h02);
        chk(i_ufc_remote_model.got_q[1], 8'h11);
        complete_run();
    end
endmodule : tb_ufc_flow_ctrl
bind ufc_flow_ctrl ufc_chk_props i_ufc_chk_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .reg_rdata_o(reg_rdata_o), .rx_char_i(rx_char_i), .tx_busy_i(tx_busy_i),
    .tx_char_o(tx_char_o), .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .sleep_o(sleep_o));
`default_nettype wire

// File: tb/ufc_flow_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_chk_props
    import ufc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ufc_pkg::ufc_req_t req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire ufc_pkg::ufc_char_t rx_char_i,
    input wire logic tx_busy_i,
    input wire ufc_pkg::ufc_char_t tx_char_o,
    input wire logic cts_n_i,
    input wire logic rts_n_o,
    input wire logic sleep_o
);
    logic [7:0] lcr_r;
    logic [7:0] sfr_r;
    logic [7:0] efr_r;
    logic fen_r;
    logic bf;
    assign bf = (lcr_r == 8'hBF);
    // Shadow of the bank-select state, rebuilt from port traffic only
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lcr_r <= 8'h1D;
            sfr_r <= 8'h00;
            efr_r <= 8'h00;
            fen_r <= 1'b0;
        end
        else if (req_i.wr)
        begin
            if (req_i.addr == 3'h3) lcr_r <= req_i.wdata;
            if (bf && req_i.addr == 3'h1) sfr_r <= req_i.wdata;
            if (bf && !sfr_r[2] && req_i.addr == 3'h2) efr_r <= req_i.wdata;
            if (!bf && req_i.addr == 3'h2) fen_r <= req_i.wdata[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_efr_rd;
        req_i.rd && req_i.addr == 3'h2 && bf && !sfr_r[2];
    endsequence
    sequence s_ident_rd;
        req_i.rd && req_i.addr == 3'h2 && (!bf || sfr_r[2]);
    endsequence
    sequence s_cts_off;
        (efr_r[7] && cts_n_i) [*4];
    endsequence
    AST_EFR_READBACK: assert property (s_efr_rd |=> reg_rdata_o == $past(efr_r))
        else $error("enhanced feature readback wrong");
    AST_IDENT_MIRROR: assert property (s_ident_rd |=> reg_rdata_o[7:6] == {2{$past(fen_r)}})
        else $error("ident top bits do not mirror fifo enable");
    AST_LCR_READBACK: assert property (req_i.rd && req_i.addr == 3'h3 |=> reg_rdata_o == $past(lcr_r))
        else $error("line control readback wrong");
    AST_RDATA_HOLD: assert property (!req_i.rd |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    AST_TX_ONE_PULSE: assert property (tx_char_o.valid |=> !tx_char_o.valid)
        else $error("transmit valid longer than one cycle");
    AST_TX_NOT_BUSY: assert property (tx_char_o.valid |-> !$past(tx_busy_i))
        else $error("transmit start while transmitter busy");
    AST_CTS_GATE: assert property (s_cts_off |=> !tx_char_o.valid)
        else $error("transmit start while clear-to-send inactive");
    AST_SLEEP_GATE: assert property ((!efr_r[4]) [*2] |-> !sleep_o)
        else $error("sleep allowed with enhanced gate clear");
endmodule : ufc_chk_props
`default_nettype wire

// File: tb/ufc_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_remote_model
    import ufc_pkg::*;
#(
    parameter logic [7:0] PAUSE_CHAR = 8'h13,
    parameter logic [7:0] RESUME_CHAR = 8'h11,
    parameter int BUSY_CYC = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ufc_pkg::ufc_char_t tx_char_i,
    input wire logic rts_n_i,
    output ufc_pkg::ufc_char_t rx_char_o,
    output logic tx_busy_o
);
    logic stall;
    logic obey_rts;
    logic paused;
    int cnt;
    logic [7:0] got_q[$];
    initial
    begin
        stall = 1'b0;
        obey_rts = 1'b0;
        rx_char_o = '0;
        tx_busy_o = 1'b0;
    end
    // Stall keeps the line busy indefinitely once the next character starts, so the bench can fill the FIFO
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_busy_o <= 1'b0;
            cnt <= 0;
            paused <= 1'b0;
        end
        else if (tx_char_i.valid)
        begin
            got_q.push_back(tx_char_i.data);
            tx_busy_o <= 1'b1;
            cnt <= BUSY_CYC;
            if (tx_char_i.data == PAUSE_CHAR) paused <= 1'b1;
            if (tx_char_i.data == RESUME_CHAR) paused <= 1'b0;
        end
        else if (cnt > 0) cnt <= cnt - 1;
        else if (!stall) tx_busy_o <= 1'b0;
    end
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clk_i);
        while ((paused || (obey_rts && rts_n_i)) && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        rx_char_o.valid = 1'b1;
        rx_char_o.data = b;
        @(negedge clk_i);
        rx_char_o.valid = 1'b0;
        // Released data is inverted so a stale byte is never mistaken for a fresh one
        rx_char_o.data = ~b;
    endtask : send
endmodule : ufc_remote_model
`default_nettype wire
